// >>> verilog/disk_cmd_exec.sv
// Task-file command executor: diagnostics, cache flushes, track format.
// Assumes synchronous task-file strobes from the host interface logic.
`timescale 1ns/1ns
`include "disk_cmd_regs.svh"
module disk_cmd_exec #(
    parameter logic [27:0] MAX_LBA = 28'h0FFFFFF,
    parameter int SECTORS_PER_TRACK = 63,
    parameter int DIAG_CYCLES = `DIAG_CYCLES,
    parameter logic DEVICE_ID = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Task-file register port
    input wire logic [2:0] tf_addr_i,
    input wire logic tf_wr_i,
    input wire logic tf_rd_i,
    input wire logic [7:0] tf_wdata_i,
    input wire logic high_order_byte_select_i,
    output logic [7:0] tf_rdata_o,
    // Diagnostic outcome from self-test logic
    input wire logic [7:0] diag_code_i,
    // Media backend
    input wire logic cache_dirty_i,
    input wire logic sector_ack_i,
    output logic write_strobe_o,
    output logic write_zero_o,
    output logic [27:0] write_lba_o,
    // Status
    output logic busy_o,
    output logic [7:0] status_o,
    output logic [7:0] error_flags_o
);
    import disk_cmd_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE, C_DIAG, C_MEDIA_START, C_MEDIA_WAIT, C_FINISH
    } cmd_state_t;

    localparam logic [31:0] DIAG_LAST = 32'(DIAG_CYCLES - 1);

    cmd_state_t state_reg, state_next;
    logic [7:0] error_flags_reg, error_flags_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] device_head_select_reg, device_head_select_next;
    logic [7:0] command_opcode_reg, command_opcode_next;
    // Current and previous bytes: count, sector, cyl low, cyl high
    logic [7:0] cur_reg [4], cur_next [4];
    logic [7:0] prev_reg [4], prev_next [4];
    logic [7:0] feat_reg, feat_next;
    logic [31:0] timer_reg, timer_next;
    logic [7:0] result_err_reg, result_err_next;
    logic [7:0] result_st_reg, result_st_next;
    media_req_t mreq;
    media_rsp_t mrsp;
    track_addr_t taddr;

    // Index of an address register in the current/previous arrays
    function automatic logic [1:0] addr_idx(input logic [2:0] a);
        return 2'(a - `TF_ADDR_SECT_COUNT);
    endfunction

    function automatic logic is_addr_reg(input logic [2:0] a);
        return (a >= `TF_ADDR_SECT_COUNT) && (a <= `TF_ADDR_CYL_HIGH);
    endfunction

    assign taddr.use_lba = device_head_select_reg[`DH_LBA_BIT];
    assign taddr.lba = {device_head_select_reg[`DH_HEAD_MSB:0],
                        cur_reg[3], cur_reg[2], cur_reg[1]};
    assign taddr.cylinder = {cur_reg[3], cur_reg[2]};
    assign taddr.head = device_head_select_reg[`DH_HEAD_MSB:0];

    assign mreq.valid = (state_reg == C_MEDIA_START);
    assign mreq.op = (command_opcode_reg == `OPC_FORMAT_TRACK) ? MEDIA_ZERO_TRACK
                                                               : MEDIA_FLUSH;
    assign mreq.addr = taddr;

    media_seq #(
        .SECTORS_PER_TRACK(SECTORS_PER_TRACK)
    ) u_media_seq (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .req_i(mreq),
        .rsp_o(mrsp),
        .cache_dirty_i(cache_dirty_i),
        .sector_ack_i(sector_ack_i),
        .write_strobe_o(write_strobe_o),
        .write_zero_o(write_zero_o),
        .write_lba_o(write_lba_o)
    );

    // Success and abort status words, and the abort error code
    localparam logic [7:0] ST_GOOD = 8'h50;
    localparam logic [7:0] ST_BAD = 8'h51;
    localparam logic [7:0] ER_ABORT = 8'h04;

    always_comb begin
        state_next = state_reg;
        error_flags_next = error_flags_reg;
        status_next = status_reg;
        device_head_select_next = device_head_select_reg;
        command_opcode_next = command_opcode_reg;
        feat_next = feat_reg;
        timer_next = timer_reg;
        result_err_next = result_err_reg;
        result_st_next = result_st_reg;
        for (int i = 0; i < 4; i++) begin
            cur_next[i] = cur_reg[i];
            prev_next[i] = prev_reg[i];
        end
        // Host writes are ignored while busy, so executing state stays stable
        if (tf_wr_i && state_reg == C_IDLE) begin
            if (is_addr_reg(tf_addr_i)) begin
                prev_next[addr_idx(tf_addr_i)] = cur_reg[addr_idx(tf_addr_i)];
                cur_next[addr_idx(tf_addr_i)] = tf_wdata_i;
            end else if (tf_addr_i == `TF_ADDR_FEATURE) begin
                feat_next = tf_wdata_i;
            end else if (tf_addr_i == `TF_ADDR_DEV_HEAD) begin
                device_head_select_next = tf_wdata_i;
            end else if (tf_addr_i == `TF_ADDR_CMD &&
                         device_head_select_reg[`DH_DEV_BIT] == DEVICE_ID) begin
                command_opcode_next = tf_wdata_i;
                status_next[`ST_BUSY_BIT] = 1'b1;
                unique case (tf_wdata_i)
                    `OPC_DIAG: begin
                        timer_next = 32'h0;
                        state_next = C_DIAG;
                    end
                    `OPC_FLUSH, `OPC_FLUSH_EXT: begin
                        state_next = C_MEDIA_START;
                    end
                    `OPC_FORMAT_TRACK: begin
                        // Out-of-range block address aborts before any write
                        if (device_head_select_reg[`DH_LBA_BIT] && taddr.lba > MAX_LBA) begin
                            result_err_next = ER_ABORT;
                            result_st_next = ST_BAD;
                            state_next = C_FINISH;
                        end else begin
                            state_next = C_MEDIA_START;
                        end
                    end
                    default: begin
                        result_err_next = ER_ABORT;
                        result_st_next = ST_BAD;
                        state_next = C_FINISH;
                    end
                endcase
            end
        end
        unique case (state_reg)
            C_IDLE: begin
            end
            C_DIAG: begin
                if (timer_reg == DIAG_LAST) begin
                    result_err_next = diag_code_i;
                    result_st_next = ST_GOOD;
                    state_next = C_FINISH;
                end else begin
                    timer_next = timer_reg + 32'h1;
                end
            end
            C_MEDIA_START: begin
                state_next = C_MEDIA_WAIT;
            end
            C_MEDIA_WAIT: begin
                if (mrsp.done) begin
                    result_err_next = mrsp.fault ? ER_ABORT : 8'h00;
                    result_st_next = mrsp.fault ? ST_BAD : ST_GOOD;
                    if (command_opcode_reg == `OPC_FORMAT_TRACK && taddr.use_lba) begin
                        cur_next[1] = mrsp.last_lba[7:0];
                        cur_next[2] = mrsp.last_lba[15:8];
                        cur_next[3] = mrsp.last_lba[23:16];
                        device_head_select_next[`DH_HEAD_MSB:0] = mrsp.last_lba[27:24];
                    end
                    state_next = C_FINISH;
                end
            end
            C_FINISH: begin
                error_flags_next = result_err_reg;
                status_next = result_st_reg;
                state_next = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= C_IDLE;
            error_flags_reg <= `ERR_RESET;
            status_reg <= `STATUS_RESET;
            device_head_select_reg <= `DEV_HEAD_RESET;
            command_opcode_reg <= 8'h00;
            feat_reg <= 8'h00;
            timer_reg <= 32'h0;
            result_err_reg <= 8'h00;
            result_st_reg <= `STATUS_RESET;
            for (int i = 0; i < 4; i++) begin
                cur_reg[i] <= 8'h00;
                prev_reg[i] <= 8'h00;
            end
        end else begin
            state_reg <= state_next;
            error_flags_reg <= error_flags_next;
            status_reg <= status_next;
            device_head_select_reg <= device_head_select_next;
            command_opcode_reg <= command_opcode_next;
            feat_reg <= feat_next;
            timer_reg <= timer_next;
            result_err_reg <= result_err_next;
            result_st_reg <= result_st_next;
            for (int i = 0; i < 4; i++) begin
                cur_reg[i] <= cur_next[i];
                prev_reg[i] <= prev_next[i];
            end
        end
    end

    // Read mux; while busy only status carries meaning
    always_comb begin
        tf_rdata_o = 8'h00;
        if (tf_rd_i) begin
            if (is_addr_reg(tf_addr_i)) begin
                tf_rdata_o = high_order_byte_select_i ? prev_reg[addr_idx(tf_addr_i)]
                                                      : cur_reg[addr_idx(tf_addr_i)];
            end else if (tf_addr_i == `TF_ADDR_FEATURE) begin
                tf_rdata_o = error_flags_reg;
            end else if (tf_addr_i == `TF_ADDR_DEV_HEAD) begin
                tf_rdata_o = device_head_select_reg;
            end else if (tf_addr_i == `TF_ADDR_CMD) begin
                tf_rdata_o = status_reg;
            end
        end
    end

    assign busy_o = status_reg[`ST_BUSY_BIT];
    assign status_o = status_reg;
    assign error_flags_o = error_flags_reg;
endmodule

// >>> include/disk_cmd_regs.svh
// Register offsets, field positions, opcodes and timing counts for the
// task-file command executor. Assumes an 8-bit task-file register port.
// What this block does
// - Opcode 90h runs internal diagnostics; the outcome lands in the error register.
// - After diagnostics the error register holds a result code, not flags.
// - Opcode E7h writes back cache; good status only after write-back ends.
// - Opcode EAh likewise commits every cached write before good status.
// - Extended registers keep current and previous bytes, chosen by high-order select.
// - Opcode 50h formats one logical track, zeroing every good sector.
// - Track format does no read-back verify; only the write pass counts.
// - Any format table is accepted, its descriptors ignored, all sectors zeroed.
// - Track layout and 1:1 interleave stay fixed whatever numbering is given.
// - Logical mode: sector bits 0-7, cyl low 8-15, cyl high 16-23, head 24-27.
// - Physical mode: cylinder registers give cylinder, head field gives head.
// - After logical format, address registers return the current address likewise.
// - Logical address beyond range ends track format with abort flag.
// - Logical mode formats the track containing the given block address.
`ifndef DISK_CMD_REGS_SVH
`define DISK_CMD_REGS_SVH

// Task-file register addresses (3-bit)
`define TF_ADDR_DATA 3'h0
`define TF_ADDR_FEATURE 3'h1
`define TF_ADDR_SECT_COUNT 3'h2
`define TF_ADDR_SECT_NUM 3'h3
`define TF_ADDR_CYL_LOW 3'h4
`define TF_ADDR_CYL_HIGH 3'h5
`define TF_ADDR_DEV_HEAD 3'h6
`define TF_ADDR_CMD 3'h7

// Opcodes
`define OPC_DIAG 8'h90
`define OPC_FLUSH 8'hE7
`define OPC_FLUSH_EXT 8'hEA
`define OPC_FORMAT_TRACK 8'h50

// Device control: high-order byte select bit
`define CTL_HOB_BIT 7

// Device/head fields
`define DH_LBA_BIT 6
`define DH_DEV_BIT 4
`define DH_HEAD_MSB 3

// Status bits
`define ST_BUSY_BIT 7
`define ST_READY_BIT 6
`define ST_SEEK_DONE_BIT 4
`define ST_ERR_BIT 0

// Error bits
`define ER_ID_NOT_FOUND_BIT 4
`define ER_ABORT_BIT 2

// Reset values
`define ERR_RESET 8'h01
`define STATUS_RESET 8'h50
`define DEV_HEAD_RESET 8'hA0

// Diagnostic result code: device passed
`define DIAG_PASS_CODE 8'h01

// Timing
`define DIAG_TIME_US 10
`define DIAG_CYCLES ((`DIAG_TIME_US * 1000) / 10)

`endif

// >>> include/disk_cmd_pkg.sv
// Types shared by the command executor and its media sequencer.
// Assumes the constants header is included alongside.
package disk_cmd_pkg;

    typedef enum logic [1:0] {
        MEDIA_NONE,
        MEDIA_FLUSH,
        MEDIA_ZERO_TRACK
    } media_op_t;

    typedef struct packed {
        logic [27:0] lba;
        logic [15:0] cylinder;
        logic [3:0] head;
        logic use_lba;
    } track_addr_t;

    typedef struct packed {
        logic valid;
        media_op_t op;
        track_addr_t addr;
    } media_req_t;

    typedef struct packed {
        logic done;
        logic fault;
        logic [27:0] last_lba;
    } media_rsp_t;

endpackage

// >>> verilog/media_seq.sv
// Media sequencer: runs cache write-back and single-track zeroing.
// Assumes the media backend acks each sector write with a one-cycle pulse.
`timescale 1ns/1ns
`include "disk_cmd_regs.svh"
module media_seq #(
    parameter int SECTORS_PER_TRACK = 63
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Request and response
    input disk_cmd_pkg::media_req_t req_i,
    output disk_cmd_pkg::media_rsp_t rsp_o,
    // Media backend
    input wire logic cache_dirty_i,
    input wire logic sector_ack_i,
    output logic write_strobe_o,
    output logic write_zero_o,
    output logic [27:0] write_lba_o
);
    import disk_cmd_pkg::*;

    typedef enum logic [1:0] {S_IDLE, S_FLUSH, S_ZERO, S_DONE} seq_state_t;

    localparam logic [7:0] LAST_SECT = 8'(SECTORS_PER_TRACK - 1);

    seq_state_t state_reg, state_next;
    logic [7:0] sect_reg, sect_next;
    logic [27:0] base_reg, base_next;
    logic [27:0] lba_reg, lba_next;

    // Track base: fixed layout, 1:1 interleave, numbering ignored
    function automatic logic [27:0] track_base(input track_addr_t a);
        logic [27:0] b;
        b = 28'h0;
        if (a.use_lba) begin
            b = a.lba - (a.lba % 28'(SECTORS_PER_TRACK));
        end else begin
            b = 28'(({12'h0, a.cylinder} * 28'h10 + 28'(a.head))
                * 28'(SECTORS_PER_TRACK));
        end
        return b;
    endfunction

    always_comb begin
        state_next = state_reg;
        sect_next = sect_reg;
        base_next = base_reg;
        lba_next = lba_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (req_i.valid && req_i.op == MEDIA_FLUSH) begin
                    state_next = S_FLUSH;
                end else if (req_i.valid && req_i.op == MEDIA_ZERO_TRACK) begin
                    base_next = track_base(req_i.addr);
                    sect_next = 8'h00;
                    lba_next = req_i.addr.lba;
                    state_next = S_ZERO;
                end
            end
            S_FLUSH: begin
                // Done only once nothing dirty remains
                if (!cache_dirty_i) begin
                    state_next = S_DONE;
                end
            end
            S_ZERO: begin
                // Write pass only; no verify read follows
                if (sector_ack_i) begin
                    if (sect_reg == LAST_SECT) begin
                        state_next = S_DONE;
                    end else begin
                        sect_next = sect_reg + 8'h01;
                    end
                end
            end
            S_DONE: begin
                state_next = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= S_IDLE;
            sect_reg <= 8'h00;
            base_reg <= 28'h0;
            lba_reg <= 28'h0;
        end else begin
            state_reg <= state_next;
            sect_reg <= sect_next;
            base_reg <= base_next;
            lba_reg <= lba_next;
        end
    end

    assign write_strobe_o = (state_reg == S_ZERO);
    assign write_zero_o = (state_reg == S_ZERO);
    assign write_lba_o = base_reg + 28'(sect_reg);
    assign rsp_o.done = (state_reg == S_DONE);
    assign rsp_o.fault = 1'b0;
    assign rsp_o.last_lba = lba_reg;
endmodule

// >>> tb/disk_cmd_exec_assertions.sv
// Port-level checker for the task-file command executor.
// Assumes only the executor's ports; the device select is mirrored here.
`timescale 1ns/1ns
module disk_cmd_exec_assertions #(
    parameter int SECTORS_PER_TRACK = 63,
    parameter int DIAG_CYCLES = 1000,
    parameter logic DEVICE_ID = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Task file and media
    input wire logic [2:0] tf_addr_i,
    input wire logic tf_wr_i,
    input wire logic [7:0] tf_wdata_i,
    input wire logic [7:0] diag_code_i,
    input wire logic cache_dirty_i,
    input wire logic sector_ack_i,
    input wire logic write_strobe_o,
    input wire logic write_zero_o,
    // Status
    input wire logic busy_o,
    input wire logic [7:0] status_o,
    input wire logic [7:0] error_flags_o
);
    logic [7:0] op_reg;
    int ack_cnt;
    int busy_cnt;
    logic take;
    logic flush_op;
    logic dev_sel;
    assign take = tf_wr_i && tf_addr_i == 3'h7 && !busy_o && dev_sel == DEVICE_ID;
    // Dev/head writes land only while idle, so mirror them the same way
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dev_sel <= 1'b0;
        end else if (tf_wr_i && tf_addr_i == 3'h6 && !busy_o) begin
            dev_sel <= tf_wdata_i[4];
        end
    end
    assign flush_op = op_reg == 8'hE7 || op_reg == 8'hEA;
    // Counts restart at each taken command so a stale pass cannot leak in
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_reg <= 8'h00;
            ack_cnt <= 0;
            busy_cnt <= 0;
        end else if (take) begin
            op_reg <= tf_wdata_i;
            ack_cnt <= 0;
            busy_cnt <= 0;
        end else begin
            ack_cnt <= ack_cnt + int'(sector_ack_i && write_strobe_o);
            busy_cnt <= busy_cnt + int'(busy_o);
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    a_busy_on_take: assert property (take |=> busy_o)
        else $error("busy did not rise after command");
    a_status_busy: assert property (status_o[7] == busy_o)
        else $error("status busy bit differs from busy");
    a_flush_holds: assert property (
        busy_o && cache_dirty_i && flush_op |=> busy_o)
        else $error("flush ended with dirty cache");
    a_flush_good: assert property (
        $fell(busy_o) && flush_op
        |-> status_o == 8'h50 && error_flags_o == 8'h00)
        else $error("flush completion status wrong");
    a_diag_code: assert property (
        $fell(busy_o) && op_reg == 8'h90
        |-> error_flags_o == diag_code_i && status_o == 8'h50)
        else $error("diagnostic code not in error register");
    a_diag_length: assert property (
        $fell(busy_o) && op_reg == 8'h90 |-> busy_cnt >= DIAG_CYCLES)
        else $error("diagnostic too short");
    a_zero_only: assert property (
        write_strobe_o |-> write_zero_o && busy_o && op_reg == 8'h50)
        else $error("media write outside zero pass");
    a_one_track: assert property (
        $fell(busy_o) && op_reg == 8'h50 && error_flags_o == 8'h00
        |-> ack_cnt == SECTORS_PER_TRACK)
        else $error("track not fully zeroed");
    a_abort_clean: assert property (
        $fell(busy_o) && op_reg == 8'h50 && error_flags_o[2]
        |-> status_o == 8'h51 && ack_cnt == 0)
        else $error("aborted format touched media");
    a_bad_opcode: assert property (
        $fell(busy_o) && !(op_reg inside {8'h90, 8'hE7, 8'hEA, 8'h50})
        |-> status_o == 8'h51 && error_flags_o == 8'h04)
        else $error("unknown opcode not aborted");
    c_flush: cover property ($fell(busy_o) && flush_op);
    c_bad: cover property ($fell(busy_o) && error_flags_o == 8'h04);
    c_diag: cover property ($fell(busy_o) && op_reg == 8'h90);
    c_format: cover property ($fell(busy_o) && op_reg == 8'h50 && ack_cnt > 0);
endmodule

bind disk_cmd_exec disk_cmd_exec_assertions #(
    .SECTORS_PER_TRACK(SECTORS_PER_TRACK),
    .DIAG_CYCLES(DIAG_CYCLES),
    .DEVICE_ID(DEVICE_ID)
) u_chk (.ref_clk_i, .nrst_i, .tf_addr_i, .tf_wr_i, .tf_wdata_i, .diag_code_i,
    .cache_dirty_i, .sector_ack_i, .write_strobe_o, .write_zero_o, .busy_o,
    .status_o, .error_flags_o);

// >>> tb/media_model.sv
// Media backend model: a write cache that drains slowly and sector acks.
// Assumes the executor holds its write strobe through the zero pass.
`timescale 1ns/1ns
module media_model #(
    parameter int ACK_GAP = 3,
    parameter int DRAIN = 20
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Executor side
    input wire logic write_strobe_i,
    input wire logic dirty_set_i,
    output logic cache_dirty_o,
    output logic sector_ack_o
);
    int gap;
    int drain;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap <= 0;
            drain <= 0;
            sector_ack_o <= 1'b0;
        end else begin
            // Slow acks only for writes; no read-back pass exists
            gap <= write_strobe_i && gap < ACK_GAP - 1 ? gap + 1 : 0;
            sector_ack_o <= write_strobe_i && gap == ACK_GAP - 1;
            // Dirty data stays for DRAIN cycles, whatever the executor wants
            drain <= dirty_set_i ? DRAIN : (drain > 0 ? drain - 1 : 0);
        end
    end
    assign cache_dirty_o = drain > 0;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the task-file command executor.
// Assumes short diagnostic and track counts set below.
`timescale 1ns/1ns
module testbench;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] tf_addr_i = 3'h0;
    logic tf_wr_i = 1'b0;
    logic tf_rd_i = 1'b0;
    logic [7:0] tf_wdata_i = 8'h00;
    logic hob_i = 1'b0;
    logic [7:0] diag_code_i = 8'h00;
    logic dirty_set = 1'b0;
    logic cache_dirty_i, sector_ack_i, write_strobe_o, write_zero_o, busy_o;
    logic [7:0] tf_rdata_o, status_o, error_flags_o;
    logic [27:0] write_lba_o;
    logic [27:0] seen[$];
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    disk_cmd_exec #(.MAX_LBA(28'h0000FFF), .SECTORS_PER_TRACK(4), .DIAG_CYCLES(4)) dut (
        .ref_clk_i, .nrst_i, .tf_addr_i, .tf_wr_i, .tf_rd_i, .tf_wdata_i,
        .high_order_byte_select_i(hob_i), .tf_rdata_o, .diag_code_i, .cache_dirty_i,
        .sector_ack_i, .write_strobe_o, .write_zero_o, .write_lba_o, .busy_o,
        .status_o, .error_flags_o);
    media_model u_media (.ref_clk_i, .nrst_i, .write_strobe_i(write_strobe_o),
        .dirty_set_i(dirty_set), .cache_dirty_o(cache_dirty_i), .sector_ack_o(sector_ack_i));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        if (sector_ack_i === 1'b1 && write_strobe_o === 1'b1) seen.push_back(write_lba_o);
        cycles++;
        // Whole run needs a few hundred cycles; this leaves wide margin
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [27:0] exp, input logic [27:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        tf_addr_i <= a;
        tf_wdata_i <= d;
        tf_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        tf_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic high_order_byte_select, output logic [7:0] d);
        @(posedge ref_clk_i);
        tf_addr_i <= a;
        hob_i <= high_order_byte_select;
        tf_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        d = tf_rdata_o;
        tf_rd_i <= 1'b0;
    endtask
    task automatic wait_idle();
        int i;
        i = 0;
        @(negedge ref_clk_i);
        while (busy_o !== 1'b0 && i < 500) begin
            @(negedge ref_clk_i);
            i++;
        end
        cmp("busy at completion", 28'h0, {27'h0, busy_o});
    endtask
    task automatic chk_regs(input logic [7:0] st, input logic [7:0] er);
        logic [7:0] d;
        rd(3'h7, 1'b0, d);
        cmp("status", {20'h0, st}, {20'h0, d});
        rd(3'h1, 1'b0, d);
        cmp("error", {20'h0, er}, {20'h0, d});
    endtask
    task automatic t_reset();
        logic [7:0] d;
        chk_regs(8'h50, 8'h01);
        rd(3'h6, 1'b0, d);
        cmp("dev head", 28'hA0, {20'h0, d});
    endtask
    task automatic t_diag();
        diag_code_i <= 8'h81;
        wr(3'h6, 8'hA0);
        wr(3'h7, 8'h90);
        wait_idle();
        chk_regs(8'h50, 8'h81);
    endtask
    task automatic t_bad();
        wr(3'h7, 8'h3C);
        wait_idle();
        chk_regs(8'h51, 8'h04);
        wr(3'h6, 8'hB0);
        wr(3'h7, 8'h90);
        @(negedge ref_clk_i);
        cmp("busy for other device", 28'h0, {27'h0, busy_o});
        chk_regs(8'h51, 8'h04);
        wr(3'h6, 8'hA0);
    endtask
    task automatic t_flush(input logic [7:0] op);
        @(posedge ref_clk_i);
        dirty_set <= 1'b1;
        @(posedge ref_clk_i);
        dirty_set <= 1'b0;
        wr(3'h7, op);
        wr(3'h7, 8'h90);
        cmp("busy while dirty", 28'h1, {27'h0, busy_o});
        wait_idle();
        cmp("cache clean at done", 28'h0, {27'h0, cache_dirty_i});
        chk_regs(8'h50, 8'h00);
    endtask
    task automatic t_hob();
        logic [7:0] d;
        wr(3'h3, 8'h12);
        wr(3'h3, 8'h34);
        rd(3'h3, 1'b0, d);
        cmp("current byte", 28'h34, {20'h0, d});
        rd(3'h3, 1'b1, d);
        cmp("previous byte", 28'h12, {20'h0, d});
    endtask
    task automatic t_fmt(input logic [7:0] sec, input logic [7:0] cl, input logic [7:0] ch,
        input logic [7:0] dh, input logic [27:0] base, input int n, input logic [7:0] st,
        input logic [7:0] er);
        logic [7:0] d;
        seen.delete();
        for (int k = 0; k < 4; k++) wr(3'h0, 8'hC3 + 8'(k));
        wr(3'h3, sec);
        wr(3'h4, cl);
        wr(3'h5, ch);
        wr(3'h6, dh);
        wr(3'h7, 8'h50);
        wait_idle();
        chk_regs(st, er);
        cmp("sectors zeroed", 28'(n), 28'(seen.size()));
        for (int k = 0; k < n && k < seen.size(); k++) begin
            cmp("zeroed lba", base + 28'(k), seen[k]);
        end
        rd(3'h3, 1'b0, d);
        cmp("sector reg after", {20'h0, sec}, {20'h0, d});
        rd(3'h4, 1'b0, d);
        cmp("cyl low after", {20'h0, cl}, {20'h0, d});
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_diag();
        t_flush(8'hE7);
        t_flush(8'hEA);
        t_hob();
        t_bad();
        t_fmt(8'h05, 8'h01, 8'h00, 8'hE0, 28'h0000104, 4, 8'h50, 8'h00);
        t_fmt(8'h09, 8'h01, 8'h00, 8'hA2, 28'h0000048, 4, 8'h50, 8'h00);
        t_fmt(8'h00, 8'h00, 8'h01, 8'hE0, 28'h0, 0, 8'h51, 8'h04);
        close_out();
    end
endmodule
